// >>> led_stage_pkg.sv
// package of constants for the led output stage control
// Behaviour
// [R1] pull-up on after short delay, blanking high
// [R2] pull-up off at once when blanking falls
// [R3] open-detected channels forced off
// [R4] four groups by channel index modulo four
// [R5] groups switch on in order, staggered
// [R6] groups switch off with same stagger
// [R7] open detect sampled 33rd edge, on channels
// [R8] thermal error forces all off until restart
// [R9] forced channel released by later normal result
package led_stage_pkg;
   localparam int CHANNELS = 16;
   localparam int GROUPS = 4;
   localparam int CLOCK_PERIOD_NS = 8;
   localparam int PRECHARGE_DELAY_NS = 24;
   localparam int PRECHARGE_CYCLES = (PRECHARGE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int GROUP_DELAY_NS = 16;
   localparam int GROUP_DELAY_CYCLES = (GROUP_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int DETECT_EDGE = 33;
   localparam logic [15:0] RESET_CHANNELS = 16'h0000;
endpackage : led_stage_pkg

// >>> group_stagger.sv
// delay line that staggers one group of channel enables
module group_stagger
   import led_stage_pkg::*;
#(
   parameter int DEPTH = 1
) (
   input wire logic CLOCK_IN,
   input wire logic NRST_IN,
   input wire logic [3:0] GROUP_IN,
   output logic [3:0] GROUP_OUT
);
   logic [3:0] line [DEPTH];

   if (DEPTH < 1) begin : g_bad_depth
      $error("group_stagger depth below one");
   end

   // [R6] same delay both edges
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) begin
         for (int i = 0; i < DEPTH; i++) line[i] <= 4'h0;
      end else begin
         line[0] <= GROUP_IN;
         for (int i = 1; i < DEPTH; i++) line[i] <= line[i-1];
      end
   end

   assign GROUP_OUT = line[DEPTH-1];
endmodule : group_stagger

// >>> led_output_stage_control.sv
// sixteen channel output stage: pre-charge, auto off, staggered switching
module led_output_stage_control
   import led_stage_pkg::*;
#(
   parameter int GROUP_DELAY = GROUP_DELAY_CYCLES,
   parameter int PRECHARGE_DELAY = PRECHARGE_CYCLES
) (
   input wire logic CLOCK_IN,
   input wire logic NRST_IN,
   input wire logic BLANK_IN,
   input wire logic [15:0] PWM_ON_IN,
   input wire logic [15:0] OPEN_SENSE_IN,
   input wire logic THERMAL_ERROR_FLAG_IN,
   output logic [15:0] CHANNEL_OUTPUT_OUT,
   output logic [15:0] OPEN_DETECT_OUT,
   output logic PULLUP_OUT
);
   logic [2:0] blank_sync;
   logic blank;
   logic blank_prev;
   logic [2:0] tef_sync;
   logic thermal_error_flag;
   logic [5:0] edge_count;
   logic counting;
   logic [7:0] pre_count;
   logic thermal_off;
   logic [15:0] want;
   logic [15:0] staged;
   logic [15:0] open_detect;
   logic [15:0] next_open_detect;
   logic evaluate;
   logic [7:0] blank_age;

   // refuse delays that the counters and the drain check cannot hold
   localparam int LAST_OFF = GROUP_DELAY * (GROUPS - 1) + 2;
   localparam bit BAD_DELAY = GROUP_DELAY < 1 || LAST_OFF > 255 || PRECHARGE_DELAY < 1 || PRECHARGE_DELAY > 255;
   if (BAD_DELAY) begin : g_bad_delay
      $error("bad delay parameter");
   end

   // channel n sits in group n mod 4, lane n div 4
   function automatic logic [3:0] pick_group(input logic [15:0] v, input int g);
      logic [3:0] r;
      r = 4'h0;
      for (int k = 0; k < 4; k++) r[k] = v[4*k+g];
      return r;
   endfunction : pick_group

   // three flops per pin; a change counts once the last two agree
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) begin
         blank_sync <= 3'h7;
         tef_sync <= 3'h0;
      end else begin
         blank_sync <= {blank_sync[1:0], BLANK_IN};
         tef_sync <= {tef_sync[1:0], THERMAL_ERROR_FLAG_IN};
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) begin
         blank <= 1'b1;
         thermal_error_flag <= 1'b0;
      end else begin
         if (blank_sync[1] == blank_sync[2]) blank <= blank_sync[2];
         if (tef_sync[1] == tef_sync[2]) thermal_error_flag <= tef_sync[2];
      end
   end

   // one-cycle history of the filtered blank level
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) blank_prev <= 1'b1;
      else blank_prev <= blank;
   end

   // [R6] cycles since blanking took hold, for the drain check
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) blank_age <= 8'h00;
      else if (!blank) blank_age <= 8'h00;
      else if (blank_age != 8'hff) blank_age <= blank_age + 8'h01;
   end

   // [R1] delayed pull-up enable
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) pre_count <= 8'h00;
      else if (!blank) pre_count <= 8'h00;
      else if (pre_count < 8'(PRECHARGE_DELAY)) pre_count <= pre_count + 8'h01;
   end

   // [R2] pull-up drops with blanking
   assign PULLUP_OUT = blank && (pre_count == 8'(PRECHARGE_DELAY));

   // [R7] count edges after blanking falls
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) begin
         edge_count <= 6'h00;
         counting <= 1'b0;
      end else if (blank) begin
         edge_count <= 6'h00;
         counting <= 1'b0;
      end else if (blank_prev) begin
         edge_count <= 6'h01;
         counting <= 1'b1;
      end else if (counting) begin
         edge_count <= edge_count + 6'h01;
         if (edge_count == 6'(DETECT_EDGE)) counting <= 1'b0;
      end
   end

   // [R7] the 33rd edge after blanking falls
   assign evaluate = counting && edge_count == 6'(DETECT_EDGE);

   // [R7] only channels that are on can report open
   assign next_open_detect = evaluate ? (OPEN_SENSE_IN & CHANNEL_OUTPUT_OUT) : open_detect;

   // [R7] held until the next evaluation
   // [R9] normal result releases a channel
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) open_detect <= RESET_CHANNELS;
      else open_detect <= next_open_detect;
   end
   assign OPEN_DETECT_OUT = open_detect;

   // [R8] thermal latch, restart on first edge after blank falls clear
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) thermal_off <= 1'b0;
      else if (thermal_error_flag) thermal_off <= 1'b1;
      else if (!blank && blank_prev) thermal_off <= 1'b0;
   end

   // [R3] open channels forced off
   assign want = blank ? RESET_CHANNELS : (PWM_ON_IN & ~open_detect);

   // [R4] group partition, [R5] staggered turn-on
   for (genvar g = 0; g < GROUPS; g++) begin : g_grp
      logic [3:0] lane_out;
      group_stagger #(.DEPTH(GROUP_DELAY * g + 1)) u_stage (
         .CLOCK_IN(CLOCK_IN),
         .NRST_IN(NRST_IN),
         .GROUP_IN(pick_group(want, g)),
         .GROUP_OUT(lane_out)
      );
      for (genvar k = 0; k < 4; k++) begin : g_lane
         assign staged[4*k+g] = lane_out[k];
      end
   end

   // [R8] immediate thermal shut-off
   always_ff @(posedge CLOCK_IN) begin
      if (!NRST_IN) CHANNEL_OUTPUT_OUT <= RESET_CHANNELS;
      else if (thermal_error_flag || thermal_off) CHANNEL_OUTPUT_OUT <= RESET_CHANNELS;
      // [R3] a fault found at this edge blocks at once
      else CHANNEL_OUTPUT_OUT <= staged & ~next_open_detect;
   end

   // named steps shared by the checks below
   sequence s_evaluate;
      counting && edge_count == 6'(DETECT_EDGE);
   endsequence : s_evaluate

   sequence s_restart;
      !thermal_error_flag && !blank && blank_prev;
   endsequence : s_restart

   // pull-up checks
   a_pullup_off_blank: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R2]
      !blank |-> !PULLUP_OUT) else $error("pull-up on while not blanked");

   a_pullup_delay: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R1]
      $rose(blank) |-> !PULLUP_OUT) else $error("pull-up came on without delay");

   a_pullup_after: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R1]
      $rose(PULLUP_OUT) |-> $past(blank, 1))
      else $error("pull-up rose before blanking settled");

   // fault shut-off checks
   a_open_off: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R3]
      (CHANNEL_OUTPUT_OUT & open_detect) == 16'h0000) else $error("open channel driven");

   a_detect_hold: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R7]
      !(counting && edge_count == 6'(DETECT_EDGE)) |=> $stable(open_detect)) else $error("open detect moved");

   a_detect_sample: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R7]
      s_evaluate |=> open_detect == ($past(OPEN_SENSE_IN, 1) & $past(CHANNEL_OUTPUT_OUT, 1)))
      else $error("open detect not sampled");

   a_edge_bound: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R7]
      counting |-> edge_count <= 6'(DETECT_EDGE))
      else $error("edge count ran past evaluation");

   a_release_normal: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R9]
      $fell(open_detect[0]) |-> $past(counting, 1)) else $error("fault cleared outside evaluation");

   // thermal checks
   a_thermal_off: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R8]
      thermal_error_flag |=> CHANNEL_OUTPUT_OUT == 16'h0000) else $error("output on under thermal error");

   a_thermal_latch: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R8]
      thermal_off |=> CHANNEL_OUTPUT_OUT == 16'h0000)
      else $error("output on while thermal latch set");

   a_thermal_restart: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R8]
      $fell(thermal_off) |-> $past(blank_prev, 1) && !$past(blank, 1) && !$past(thermal_error_flag, 1))
      else $error("thermal latch cleared outside restart");

   a_thermal_clear: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R8]
      s_restart |=> !thermal_off) else $error("thermal latch kept at restart");

   // group checks
   a_group_zero_first: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R5]
      $rose(staged[1]) |-> $past(staged[0], 1) || !$past(want[0], 1)) else $error("group order broken");

   a_off_stagger: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R6]
      $fell(staged[3]) |-> !staged[2] || $past(staged[2], 1)) else $error("off stagger broken");

   a_group_map: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R4]
      g_grp[0].lane_out[1] == staged[4]) else $error("group map wrong");

   a_blank_drains: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R6]
      blank_age >= 8'(LAST_OFF) |-> CHANNEL_OUTPUT_OUT == 16'h0000)
      else $error("outputs still on after last group delay");

   // each later group turns on only after its own delay
   for (genvar g = 1; g < GROUPS; g++) begin : g_order
      a_group_delay: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R5]
         $rose(CHANNEL_OUTPUT_OUT[g]) |-> $past(want[g], GROUP_DELAY * g + 2))
         else $error("group turned on before its delay");
   end
endmodule : led_output_stage_control

// >>> led_matrix_model.sv
// far side: led columns with open leds
module led_matrix_model (
   input wire logic [15:0] CHANNEL_IN,
   input wire logic [15:0] OPEN_MASK_IN,
   output logic [15:0] SENSE_OUT
);
   // only a sinking channel with a broken led falls below threshold
   assign SENSE_OUT = CHANNEL_IN & OPEN_MASK_IN;
endmodule : led_matrix_model

// >>> led_output_stage_control_test.sv
// self-checking bench for the led output stage control
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin err_count++; \
   $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module led_output_stage_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   import led_stage_pkg::*;
   logic clk = 0, nrst = 0, blank = 1, thermal_error_flag = 0;
   logic [15:0] pwm = 16'hffff, open_mask = 16'h0000, sense, chan, odet;
   logic pull;
   int err_count = 0, n_compared = 0;
   led_output_stage_control DUT (.CLOCK_IN(clk), .NRST_IN(nrst), .BLANK_IN(blank), .PWM_ON_IN(pwm),
      .OPEN_SENSE_IN(sense), .THERMAL_ERROR_FLAG_IN(thermal_error_flag), .CHANNEL_OUTPUT_OUT(chan),
      .OPEN_DETECT_OUT(odet), .PULLUP_OUT(pull));
   led_matrix_model far_side (.CHANNEL_IN(chan), .OPEN_MASK_IN(open_mask), .SENSE_OUT(sense));
   initial begin
      forever #4 clk = ~clk;
   end
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // lvl 1: blank falls and groups turn on; lvl 0: blank rises and groups turn off
   task edges(input logic lvl);
      int t[4];
      int tp;
      tp = -1;
      for (int g = 0; g < 4; g++) t[g] = -1;
      @(posedge clk) blank <= !lvl;
      for (int c = 0; c < 30; c++) begin
         tick(1);
         if (!lvl && pull === 1'b1 && tp < 0) tp = c;
         for (int g = 0; g < 4; g++) begin
            if (t[g] < 0 && chan[g] === lvl) begin
               t[g] = c;
               `CHK("group", {4{lvl}}, {chan[g+12], chan[g+8], chan[g+4], chan[g]})
               if (lvl && g == 0) `CHK("pullup off", 1'b0, pull)
            end
         end
      end
      `CHK("group0 seen", 1'b1, t[0] >= 0)
      for (int g = 0; g < 3; g++) `CHK("stagger", GROUP_DELAY_CYCLES, t[g+1] - t[g])
      if (!lvl) `CHK("pullup delay", 1'b1, tp > t[0] && tp <= t[0] + PRECHARGE_CYCLES)
   endtask : edges
   task open_test;
      @(posedge clk) open_mask <= 16'h0020;
      edges(1);
      tick(15);
      `CHK("open detect", 16'h0020, odet)
      `CHK("auto off", 16'hffdf, chan)
      @(posedge clk) open_mask <= 16'h0000;
      edges(0);
      @(posedge clk) blank <= 0;
      tick(45);
      `CHK("open cleared", 16'h0000, odet)
      `CHK("re-enabled", 16'hffff, chan)
   endtask : open_test
   task thermal_test;
      @(posedge clk) thermal_error_flag <= 1;
      tick(6);
      `CHK("thermal off", 16'h0000, chan)
      @(posedge clk) thermal_error_flag <= 0;
      pwm <= 16'h00ff;
      tick(10);
      `CHK("thermal latched", 16'h0000, chan)
      @(posedge clk) blank <= 1;
      tick(12);
      @(posedge clk) blank <= 0;
      tick(20);
      `CHK("thermal restart", 16'h00ff, chan)
   endtask : thermal_test
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      tick(2);
      @(posedge clk) nrst <= 1;
      tick(5);
      edges(1);
      edges(0);
      open_test();
      thermal_test();
      finish_test();
   end
endmodule : led_output_stage_control_test
